// ---- inc/tc_pkg.sv ----
// ----------------------------------------------------------------------
// Timer16 shared constants
// ----------------------------------------------------------------------
package tc_pkg;
	// I/O register offsets on the 8-bit core bus
	localparam logic [5:0] TC_ADR_CAP_LO = 6'h24;
	localparam logic [5:0] TC_ADR_CAP_HI = 6'h25;
	localparam logic [5:0] TC_ADR_CMPB_LO = 6'h28;
	localparam logic [5:0] TC_ADR_CMPB_HI = 6'h29;
	localparam logic [5:0] TC_ADR_CMPA_LO = 6'h2a;
	localparam logic [5:0] TC_ADR_CMPA_HI = 6'h2b;
	localparam logic [5:0] TC_ADR_CNT_LO = 6'h2c;
	localparam logic [5:0] TC_ADR_CNT_HI = 6'h2d;
	localparam logic [5:0] TC_ADR_CTRL_B = 6'h2e;
	localparam logic [5:0] TC_ADR_CTRL_A = 6'h2f;
	localparam logic [5:0] TC_ADR_FLAGS = 6'h38;
	localparam logic [5:0] TC_ADR_IRQ_EN = 6'h39;

	// Writable bit masks, reserved bits read zero
	localparam logic [7:0] TC_CTRL_A_MASK = 8'hf3;
	localparam logic [7:0] TC_CTRL_B_MASK = 8'hc7;

	// Field positions
	localparam int TC_MODE_A_POS = 6;
	localparam int TC_MODE_B_POS = 4;
	localparam int TC_PWM_SEL_POS = 0;
	localparam int TC_FILT_POS = 7;
	localparam int TC_EDGE_POS = 6;
	localparam int TC_CS_POS = 0;
	localparam int TC_FLG_OVF = 0;
	localparam int TC_FLG_CMPA = 1;
	localparam int TC_FLG_CMPB = 2;
	localparam int TC_FLG_CAP = 3;

	// Reset values
	localparam logic [7:0] TC_RST_BYTE = 8'h00;
	localparam logic [15:0] TC_RST_WORD = 16'h0000;

	// PWM ceilings per resolution
	localparam logic [15:0] TC_TOP_8 = 16'h00ff;
	localparam logic [15:0] TC_TOP_9 = 16'h01ff;
	localparam logic [15:0] TC_TOP_10 = 16'h03ff;

	// Clock select codes
	localparam logic [2:0] TC_CS_STOP = 3'h0;
	localparam logic [2:0] TC_CS_DIV1 = 3'h1;
	localparam logic [2:0] TC_CS_DIV8 = 3'h2;
	localparam logic [2:0] TC_CS_DIV64 = 3'h3;
	localparam logic [2:0] TC_CS_DIV256 = 3'h4;
	localparam logic [2:0] TC_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TC_CS_EXT_FALL = 3'h6;

	// Capture filter depth in main clock samples
	localparam int TC_FILT_LEN = 4;
endpackage : tc_pkg

// ---- hw/tc_pin_cond.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Pin conditioner: synchroniser, optional filter, edge detector
// ----------------------------------------------------------------------
module tc_pin_cond import tc_pkg::*; #(
	parameter int FILT_LEN = TC_FILT_LEN
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic pin_i,
	input wire logic rise_sel_i,
	input wire logic filt_en_i,
	output logic event_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic [FILT_LEN-1:0] hist;
		logic lvl;
		logic ev;
	} tc_pin_s;

	tc_pin_s st_r;
	tc_pin_s st_nxt;

	// Filtered level follows the pin only after FILT_LEN equal samples
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.hist = {st_r.hist[FILT_LEN-2:0], st_r.s2};
		if (!filt_en_i) begin
			st_nxt.lvl = st_r.s2;
		end else if (&st_nxt.hist) begin
			st_nxt.lvl = 1'b1;
		end else if (~|st_nxt.hist) begin
			st_nxt.lvl = 1'b0;
		end
		// Edge of the chosen polarity on the conditioned level
		st_nxt.ev = (st_nxt.lvl != st_r.lvl) && (st_nxt.lvl == rise_sel_i);
	end

	// Single state register, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign event_o = st_r.ev;
endmodule : tc_pin_cond

// ---- hw/tc_timer16.sv ----
`timescale 1ns/1ps
module tc_timer16 import tc_pkg::*; #(
	parameter int PSC_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [5:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic gie_i,
	input wire logic [3:0] irq_ack_i,
	input wire logic capture_pin_i,
	input wire logic ext_clk_pin_i,
	output logic [7:0] rdata_o,
	output logic irq_ovf_o,
	output logic irq_cmp_a_o,
	output logic irq_cmp_b_o,
	output logic irq_cap_o,
	output logic wave_out_a_o,
	output logic wave_out_a_en_o,
	output logic wave_out_b_o,
	output logic wave_out_b_en_o
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [9:0] act_a;
		logic [9:0] act_b;
		logic [15:0] cap;
		logic [7:0] temp;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [3:0] flg;
		logic [3:0] irq_en;
		logic [3:0] irq;
		logic [PSC_W-1:0] psc;
		logic down;
		logic m_a;
		logic m_b;
		logic wave_a;
		logic wave_b;
		logic en_a;
		logic en_b;
		logic [7:0] rdata;
	} tc_state_s;

	tc_state_s st_r;
	tc_state_s st_nxt;
	logic cap_ev;
	logic ext_ev;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Ceiling for the selected resolution
	function automatic logic [15:0] top_of(input logic [1:0] sel);
		case (sel)
			2'h1: top_of = TC_TOP_8;
			2'h2: top_of = TC_TOP_9;
			default: top_of = TC_TOP_10;
		endcase
	endfunction : top_of

	// Next PWM pin level for one channel
	function automatic logic pwm_lvl(input logic [1:0] mode,
		input logic [9:0] act, input logic [15:0] nc,
		input logic [15:0] top, input logic up, input logic hit,
		input logic cur);
		if (act == 10'h000) begin
			pwm_lvl = mode[0];
		end else if ({6'h00, act} == top) begin
			pwm_lvl = ~mode[0];
		end else if (hit && nc == {6'h00, act}) begin
			pwm_lvl = up ? mode[0] : ~mode[0];
		end else begin
			pwm_lvl = cur;
		end
	endfunction : pwm_lvl

	// ------------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------------
	tc_pin_cond #(
		.FILT_LEN(TC_FILT_LEN)
	) u_cap_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(capture_pin_i),
		.rise_sel_i(st_r.ctrl_b[TC_EDGE_POS]),
		.filt_en_i(st_r.ctrl_b[TC_FILT_POS]),
		.event_o(cap_ev)
	);

	// External count clock: no filter, edge by the low select bit
	tc_pin_cond #(
		.FILT_LEN(TC_FILT_LEN)
	) u_ext_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(ext_clk_pin_i),
		.rise_sel_i(st_r.ctrl_b[TC_CS_POS]),
		.filt_en_i(1'b0),
		.event_o(ext_ev)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [2:0] cs;
		logic [1:0] psel;
		logic pwm;
		logic [15:0] top;
		logic tick;
		logic [15:0] nc;
		logic up;
		logic [3:0] f;
		tick = 1'b0;
		f = st_r.flg;
		cs = st_r.ctrl_b[TC_CS_POS +: 3];
		psel = st_r.ctrl_a[TC_PWM_SEL_POS +: 2];
		pwm = (psel != 2'h0);
		top = top_of(psel);
		nc = st_r.cnt;
		up = 1'b1;
		st_nxt = st_r;
		st_nxt.m_a = 1'b0;
		st_nxt.m_b = 1'b0;

		// Count clock selection; prescaler idles while stopped
		st_nxt.psc = (cs == TC_CS_STOP) ? '0 : st_r.psc + 1'b1;
		case (cs)
			TC_CS_STOP: tick = 1'b0;
			TC_CS_DIV1: tick = 1'b1;
			TC_CS_DIV8: tick = &st_r.psc[2:0];
			TC_CS_DIV64: tick = &st_r.psc[5:0];
			TC_CS_DIV256: tick = &st_r.psc[7:0];
			TC_CS_DIV1024: tick = &st_r.psc[9:0];
			default: tick = ext_ev;
		endcase

		// Counter stepping; only a tick can produce a match
		if (tick) begin
			if (!pwm) begin
				nc = st_r.cnt + 16'h0001;
				st_nxt.down = 1'b0;
			end else if (!st_r.down) begin
				if (st_r.cnt >= top) begin
					nc = st_r.cnt - 16'h0001;
					st_nxt.down = 1'b1;
					up = 1'b0;
				end else begin
					nc = st_r.cnt + 16'h0001;
				end
			end else begin
				if (st_r.cnt == 16'h0000) begin
					nc = 16'h0001;
					st_nxt.down = 1'b0;
				end else begin
					nc = st_r.cnt - 16'h0001;
					up = 1'b0;
				end
			end
			st_nxt.cnt = nc;
			if (pwm) begin
				st_nxt.m_a = (nc == {6'h00, st_r.act_a});
				st_nxt.m_b = (nc == {6'h00, st_r.act_b});
			end else begin
				st_nxt.m_a = (nc == st_r.cmp_a);
				st_nxt.m_b = (nc == st_r.cmp_b);
			end
		end
		if (!pwm) begin
			st_nxt.down = 1'b0;
		end

		// Active compare values: live outside PWM, latched at ceiling
		if (!pwm) begin
			st_nxt.act_a = st_r.cmp_a[9:0];
			st_nxt.act_b = st_r.cmp_b[9:0];
		end else if (tick && nc == top) begin
			st_nxt.act_a = st_r.cmp_a[9:0];
			st_nxt.act_b = st_r.cmp_b[9:0];
		end

		// Waveform pins; non-PWM compare actions are not built
		st_nxt.en_a = pwm && st_r.ctrl_a[TC_MODE_A_POS + 1];
		st_nxt.en_b = pwm && st_r.ctrl_a[TC_MODE_B_POS + 1];
		if (st_nxt.en_a) begin
			st_nxt.wave_a = pwm_lvl(st_r.ctrl_a[TC_MODE_A_POS +: 2],
				st_r.act_a, nc, top, up, tick, st_r.wave_a);
		end else begin
			st_nxt.wave_a = 1'b0;
		end
		if (st_nxt.en_b) begin
			st_nxt.wave_b = pwm_lvl(st_r.ctrl_a[TC_MODE_B_POS +: 2],
				st_r.act_b, nc, top, up, tick, st_r.wave_b);
		end else begin
			st_nxt.wave_b = 1'b0;
		end

		// Capture copies the live count in the same cycle as its flag
		if (cap_ev) begin
			st_nxt.cap = st_r.cnt;
		end

		// Register reads; count and capture low-byte reads stage the high byte
		if (rd_i) begin
			case (addr_i)
				TC_ADR_CNT_LO: begin
					st_nxt.rdata = st_r.cnt[7:0];
					st_nxt.temp = st_r.cnt[15:8];
				end
				TC_ADR_CNT_HI: st_nxt.rdata = st_r.temp;
				TC_ADR_CAP_LO: begin
					st_nxt.rdata = st_r.cap[7:0];
					st_nxt.temp = st_r.cap[15:8];
				end
				TC_ADR_CAP_HI: st_nxt.rdata = st_r.temp;
				TC_ADR_CMPA_LO: st_nxt.rdata = st_r.cmp_a[7:0];
				TC_ADR_CMPA_HI: st_nxt.rdata = st_r.cmp_a[15:8];
				TC_ADR_CMPB_LO: st_nxt.rdata = st_r.cmp_b[7:0];
				TC_ADR_CMPB_HI: st_nxt.rdata = st_r.cmp_b[15:8];
				TC_ADR_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
				TC_ADR_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
				TC_ADR_FLAGS: st_nxt.rdata = {4'h0, st_r.flg};
				TC_ADR_IRQ_EN: st_nxt.rdata = {4'h0, st_r.irq_en};
				default: st_nxt.rdata = TC_RST_BYTE;
			endcase
		end

		// Register writes; a count preset overrides a same-cycle tick
		if (wr_i) begin
			case (addr_i)
				TC_ADR_CNT_HI: st_nxt.temp = wdata_i;
				TC_ADR_CMPA_HI: st_nxt.temp = wdata_i;
				TC_ADR_CMPB_HI: st_nxt.temp = wdata_i;
				TC_ADR_CNT_LO: begin
					st_nxt.cnt = {st_r.temp, wdata_i};
					st_nxt.m_a = 1'b0;
					st_nxt.m_b = 1'b0;
				end
				TC_ADR_CMPA_LO: st_nxt.cmp_a = {st_r.temp, wdata_i};
				TC_ADR_CMPB_LO: st_nxt.cmp_b = {st_r.temp, wdata_i};
				TC_ADR_CTRL_A: st_nxt.ctrl_a = wdata_i & TC_CTRL_A_MASK;
				TC_ADR_CTRL_B: st_nxt.ctrl_b = wdata_i & TC_CTRL_B_MASK;
				TC_ADR_FLAGS: f = f & ~wdata_i[3:0];
				TC_ADR_IRQ_EN: st_nxt.irq_en = wdata_i[3:0];
				default: ;
			endcase
		end

		// Flags: clears first, then events, so a set is never lost
		f = f & ~irq_ack_i;
		if (tick && !pwm && st_r.cnt == 16'hffff) begin
			f[TC_FLG_OVF] = 1'b1;
		end
		if (tick && pwm && st_r.down && st_r.cnt == 16'h0000) begin
			f[TC_FLG_OVF] = 1'b1;
		end
		if (st_r.m_a) begin
			f[TC_FLG_CMPA] = 1'b1;
		end
		if (st_r.m_b) begin
			f[TC_FLG_CMPB] = 1'b1;
		end
		if (cap_ev) begin
			f[TC_FLG_CAP] = 1'b1;
		end
		st_nxt.flg = f;
		st_nxt.irq = f & st_nxt.irq_en & {4{gie_i}};
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Everything resets to zero: outputs low and disconnected
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign irq_ovf_o = st_r.irq[TC_FLG_OVF];
	assign irq_cmp_a_o = st_r.irq[TC_FLG_CMPA];
	assign irq_cmp_b_o = st_r.irq[TC_FLG_CMPB];
	assign irq_cap_o = st_r.irq[TC_FLG_CAP];
	assign wave_out_a_o = st_r.wave_a;
	assign wave_out_a_en_o = st_r.en_a;
	assign wave_out_b_o = st_r.wave_b;
	assign wave_out_b_en_o = st_r.en_b;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_cnt_load: assert property (
		ce_i && wr_i && addr_i == TC_ADR_CNT_LO
		|=> st_r.cnt == {$past(st_r.temp), $past(wdata_i)})
		else $error("counter not loaded from staged byte");

	a_read_stage: assert property (
		ce_i && rd_i && addr_i == TC_ADR_CNT_LO && !wr_i
		|=> st_r.temp == $past(st_r.cnt[15:8])
		&& rdata_o == $past(st_r.cnt[7:0]))
		else $error("low count read did not stage high byte");

	a_cmp_stage: assert property (
		ce_i && wr_i && addr_i == TC_ADR_CMPA_HI
		|=> st_r.cmp_a == $past(st_r.cmp_a) && st_r.temp == $past(wdata_i))
		else $error("compare high write changed compare");

	a_flag_delay: assert property (
		ce_i && st_r.m_b ##1 ce_i |-> st_r.flg[TC_FLG_CMPB])
		else $error("compare flag not set after match");

	a_cap_take: assert property (
		ce_i && cap_ev
		|=> st_r.cap == $past(st_r.cnt) && st_r.flg[TC_FLG_CAP])
		else $error("capture did not copy counter and flag");

	a_pwm_turn: assert property (
		ce_i && st_r.ctrl_a[1:0] != 2'h0 && st_r.down
		&& st_r.cnt == 16'h0000 && st_r.ctrl_b[2:0] == TC_CS_DIV1 && !wr_i
		|=> st_r.cnt == 16'h0001 && !st_r.down
		&& st_r.flg[TC_FLG_OVF])
		else $error("pwm reversal at zero wrong");

	a_static_out: assert property (
		ce_i && st_r.ctrl_a[TC_MODE_A_POS +: 2] == 2'h2
		&& st_r.ctrl_a[1:0] != 2'h0 && st_r.act_a == 10'h000
		|=> !wave_out_a_o && wave_out_a_en_o)
		else $error("zero compare output not low");

	a_irq_gate: assert property (
		ce_i && !gie_i |=> !irq_ovf_o && !irq_cmp_a_o && !irq_cmp_b_o
		&& !irq_cap_o)
		else $error("request raised with global enable off");

	a_flag_sticky: assert property (
		ce_i && st_r.flg[TC_FLG_CAP] && !wr_i && !irq_ack_i[TC_FLG_CAP]
		|=> st_r.flg[TC_FLG_CAP])
		else $error("capture flag dropped without clear");
endmodule : tc_timer16

// ---- verification/tc_cpu_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Core bus model: 8-bit register reads and writes
// ----------------------------------------------------------------------
module tc_cpu_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [5:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// Bus idles with both strobes low
	initial begin
		addr_o = 6'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// One write; strobe seen at exactly one rising edge
	task automatic wr8(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d; // Released data must not look valid
	endtask : wr8

	// One read; data is registered, so take it a cycle later
	task automatic rd8(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask : rd8

	// High byte first, so the staged byte lands with the low write
	task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
		wr8(lo + 6'h01, d[15:8]);
		wr8(lo, d[7:0]);
	endtask : wr16

	// Low byte first; callers keep interrupts off around the pair
	task automatic rd16(input logic [5:0] lo, output logic [15:0] d);
		rd8(lo, d[7:0]);
		rd8(lo + 6'h01, d[15:8]);
	endtask : rd16
endmodule : tc_cpu_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Timer16 self-checking bench
// ----------------------------------------------------------------------
module tb_top import tc_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic gie_i = 1'b0;
	logic cap_pin = 1'b0;
	logic [3:0] irq_ack = 4'h0;
	logic ext_pin = 1'b0;
	logic ce = 1'b1;
	logic ia, ib, ic;
	int divs [4] = '{8, 64, 256, 1024};
	logic [5:0] addr;
	logic [7:0] wdata, rdata, f;
	logic wr, rd, irq_ovf, wa, wa_en, wb, wb_en;
	logic [15:0] v, w;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int ha, hb;
	logic [5:0] regs [10] = '{6'h24, 6'h25, 6'h28, 6'h29, 6'h2a, 6'h2b,
		6'h2c, 6'h2d, 6'h38, 6'h30};

	tc_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	tc_timer16 dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .gie_i(gie_i),
		.irq_ack_i(irq_ack), .capture_pin_i(cap_pin),
		.ext_clk_pin_i(ext_pin), .rdata_o(rdata), .irq_ovf_o(irq_ovf),
		.irq_cmp_a_o(ia), .irq_cmp_b_o(ib), .irq_cap_o(ic),
		.wave_out_a_o(wa), .wave_out_a_en_o(wa_en), .wave_out_b_o(wb),
		.wave_out_b_en_o(wb_en));

	// ------------------------------------------------------------------
	// Clock, timeout, reporting
	// ------------------------------------------------------------------
	initial forever #25 clk_i = ~clk_i;

	// Sweeps and prescaler runs need about 25000 cycles; keep headroom
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			$display("[FAIL] %0t run did not finish", $time);
			print_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------------
	// Scenario helpers
	// ------------------------------------------------------------------
	// Capture one pulse of width wid on the selected edge, stopped counter
	task automatic cap_try(input logic [7:0] ctl, input int wid,
		input logic [7:0] ef);
		logic [15:0] k;
		k = 16'($urandom);
		cpu.wr8(TC_ADR_CTRL_B, ctl);
		cap_pin = ~ctl[6];
		repeat (8) @(negedge clk_i);
		cpu.wr8(TC_ADR_FLAGS, 8'hff);
		cpu.wr16(TC_ADR_CNT_LO, k);
		cap_pin = ctl[6];
		repeat (wid) @(negedge clk_i);
		cap_pin = ~ctl[6];
		repeat (8) @(negedge clk_i);
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({8'h00, f}, {8'h00, ef}, "capture flag");
		cpu.rd16(TC_ADR_CAP_LO, v);
		chk(v, ef[3] ? k : w, "capture value");
		if (ef[3]) w = k;
	endtask : cap_try

	// One PWM setup; count high cycles over one full up/down period
	task automatic pwm_run(input int r, input logic [1:0] m, input int c);
		int top;
		int ea;
		top = (1 << (7 + r)) - 1;
		cpu.wr8(TC_ADR_CTRL_B, 8'h00);
		cpu.wr8(TC_ADR_FLAGS, 8'hff);
		cpu.wr16(TC_ADR_CNT_LO, 16'h0000);
		cpu.wr8(TC_ADR_CTRL_A, {m, m, 2'b00, 2'(r)});
		cpu.wr16(TC_ADR_CMPA_LO, 16'(c));
		cpu.wr16(TC_ADR_CMPB_LO, 16'(top - c));
		cpu.rd16(TC_ADR_CMPA_LO, v);
		chk(v, 16'(c), "pwm compare readback");
		cpu.wr8(TC_ADR_CTRL_B, {5'h00, TC_CS_DIV1});
		repeat (2 * top + 8) @(negedge clk_i);
		ha = 0;
		hb = 0;
		repeat (2 * top) begin
			@(negedge clk_i);
			if (wa === 1'b1) ha++;
			if (wb === 1'b1) hb++;
		end
		// Non-inverted stays high 2c ticks per period, inverted the rest
		ea = (m < 2) ? 0 : (m == 2) ? 2 * c : 2 * top - 2 * c;
		chk(16'(ha), 16'(ea), "pwm a high time");
		ea = (m < 2) ? 0 : (m == 2) ? 2 * (top - c) : 2 * c;
		chk(16'(hb), 16'(ea), "pwm b high time");
		chk({14'h0, wa_en, wb_en}, {14'h0, m[1], m[1]}, "pwm drive");
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({15'h0, f[0]}, 16'h0001, "pwm overflow flag");
		cpu.wr8(TC_ADR_CTRL_B, 8'h00);
	endtask : pwm_run

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(36591));
		w = 16'h0000;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		// Count, capture, compare and flag values and one unmapped place read zero
		foreach (regs[i]) begin
			cpu.rd8(regs[i], f);
			chk({8'h00, f}, 16'h0000, "reset value");
		end
		$display("reset values done");
		// Staged 16-bit round trips; capture bytes ignore writes
		repeat (4) begin
			v = 16'($urandom);
			cpu.wr16(TC_ADR_CNT_LO, v);
			cpu.rd16(TC_ADR_CNT_LO, w);
			chk(w, v, "count round trip");
			cpu.wr16(TC_ADR_CMPA_LO, ~v);
			cpu.rd16(TC_ADR_CMPA_LO, w);
			chk(w, ~v, "compare round trip");
			cpu.wr16(TC_ADR_CAP_LO, v);
			cpu.rd16(TC_ADR_CAP_LO, w);
			chk(w, 16'h0000, "capture read only");
		end
		$display("staged access done");
		// Equal by write gives no match; counting onto it does
		v = 16'h1000 + 16'($urandom % 256);
		cpu.wr16(TC_ADR_CMPA_LO, v);
		cpu.wr16(TC_ADR_CNT_LO, v);
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({8'h00, f}, 16'h0000, "write equal no match");
		cpu.wr16(TC_ADR_CNT_LO, v - 16'h0004);
		cpu.wr8(TC_ADR_CTRL_B, {5'h00, TC_CS_DIV1});
		repeat (8) @(negedge clk_i);
		cpu.wr8(TC_ADR_CTRL_B, 8'h00);
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({8'h00, f}, 16'h0002, "compare match flag");
		cpu.wr8(TC_ADR_FLAGS, 8'hff);
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({8'h00, f}, 16'h0000, "flag cleared");
		$display("compare match done");
		// Prescaled ticks every d cycles; the stop write lands at 2.5 d
		foreach (divs[i]) begin
			v = 16'($urandom);
			cpu.wr16(TC_ADR_CNT_LO, v);
			cpu.wr8(TC_ADR_CTRL_B, 8'(i + 2));
			repeat (2 * divs[i] + divs[i] / 2 - 2) @(negedge clk_i);
			cpu.wr8(TC_ADR_CTRL_B, 8'h00);
			cpu.rd16(TC_ADR_CNT_LO, w);
			chk(w, v + 16'h0002, "prescaled count");
		end
		// External edges count once each; with ce low nothing is taken
		for (int e = 6; e < 8; e++) begin
			v = 16'($urandom);
			hb = 1 + int'($urandom % 8);
			cpu.wr16(TC_ADR_CNT_LO, v);
			cpu.wr8(TC_ADR_CTRL_B, 8'(e));
			repeat (hb) begin
				ext_pin = 1'b1;
				repeat (4) @(negedge clk_i);
				ext_pin = 1'b0;
				repeat (4) @(negedge clk_i);
			end
			repeat (2) @(negedge clk_i);
			ce = 1'b0;
			ext_pin = 1'b1;
			cpu.wr16(TC_ADR_CNT_LO, ~v);
			ext_pin = 1'b0;
			repeat (4) @(negedge clk_i);
			ce = 1'b1;
			cpu.wr8(TC_ADR_CTRL_B, 8'h00);
			cpu.rd16(TC_ADR_CNT_LO, w);
			chk(w, v + 16'(hb), "external count and freeze");
		end
		$display("count clocks done");
		// Rising, falling, filtered glitch, filtered long pulse
		cap_try(8'h40, 8, 8'h08);
		cap_try(8'h00, 8, 8'h08);
		cap_try(8'hc0, 2, 8'h00);
		cap_try(8'hc0, 8, 8'h08);
		$display("capture done");
		// Every resolution and output modes 1 to 3, random or boundary compare
		for (int r = 1; r < 4; r++) begin
			for (int m = 1; m < 4; m++) begin
				ha = (1 << (7 + r)) - 1;
				hb = (r + m) % 3;
				pwm_run(r, 2'(m), hb == 0 ? 0 : hb == 1 ? ha :
					1 + int'($urandom % (ha - 1)));
			end
		end
		$display("pwm done");
		// Last sweep left overflow and both matches; a falling edge adds
		// a capture, so all four requests can be seen gated
		cap_pin = 1'b1;
		repeat (4) @(negedge clk_i);
		cap_pin = 1'b0;
		repeat (6) @(negedge clk_i);
		cpu.rd8(TC_ADR_FLAGS, f);
		chk({8'h00, f}, 16'h000f, "all flags pending");
		cpu.wr8(TC_ADR_IRQ_EN, 8'h0f);
		repeat (3) @(negedge clk_i);
		f = {4'h0, ic, ib, ia, irq_ovf};
		chk({8'h00, f}, 16'h0000, "request without global");
		gie_i = 1'b1;
		repeat (3) @(negedge clk_i);
		f = {4'h0, ic, ib, ia, irq_ovf};
		chk({8'h00, f}, 16'h000f, "request raised");
		irq_ack = 4'hf;
		@(negedge clk_i);
		irq_ack = 4'h0;
		repeat (3) @(negedge clk_i);
		f = {4'h0, ic, ib, ia, irq_ovf};
		chk({8'h00, f}, 16'h0000, "request acknowledged");
		$display("interrupt request done");
		// Reset in mid-run clears values and disconnects outputs
		rst_i = 1'b1;
		@(negedge clk_i);
		rst_i = 1'b0;
		chk({14'h0, wa_en, wb_en}, 16'h0000, "outputs off after reset");
		cpu.rd16(TC_ADR_CMPB_LO, v);
		chk(v, 16'h0000, "compare after reset");
		$display("second reset done");
		print_verdict();
	end
endmodule : tb_top
